// file: hdl/dcs_defs.svh
`ifndef DCS_DEFS_SVH
`define DCS_DEFS_SVH

// command word bit positions
`define DCS_CW_PRESET_LO 0
`define DCS_CW_PRESET_HI 1
`define DCS_CW_DC_BRAKE_N 2
`define DCS_CW_COAST_N 3
`define DCS_CW_QSTOP_N 4
`define DCS_CW_HOLD_N 5
`define DCS_CW_START 6
`define DCS_CW_RESET 7
`define DCS_CW_JOG 8
`define DCS_CW_RAMP2 9
`define DCS_CW_VALID 10
`define DCS_CW_RELAY1 11
`define DCS_CW_RELAY4 12
`define DCS_CW_SETUP_LO 13
`define DCS_CW_SETUP_HI 14
`define DCS_CW_REVERSE 15

// option codes for selection parameters
`define DCS_RELAY_OPT_BIT11 8'h24
`define DCS_RELAY_OPT_BIT12 8'h25
`define DCS_SETUP_OPT_MULTI 4'h9
`define DCS_REV_OPT_DIGITAL 2'h0
`define DCS_REV_OPT_BUS 2'h1
`define DCS_REV_OPT_OR 2'h2
`define DCS_REV_OPT_AND 2'h3

// reset values
`define DCS_CMD_RESET 16'h0000
`define DCS_STATE_RESET 16'h0000

`endif

// file: hdl/dcs_pkg.sv
package dcs_pkg;

    typedef enum logic [1:0] {
        DCS_STOP_NONE = 2'b00,
        DCS_STOP_COAST = 2'b01,
        DCS_STOP_DC_BRAKE = 2'b10,
        DCS_STOP_RAMP = 2'b11
    } dcs_stop_t;

    typedef struct packed {
        logic [1:0] preset_sel;
        logic dc_brake;
        logic coast;
        logic quick_stop;
        logic hold_freq;
        logic ramp_stop;
        logic run_enable;
        logic trip_reset;
        logic jog;
        logic ramp_set2;
        logic relay1;
        logic relay4;
        logic [1:0] setup_sel;
        logic setup_load;
        logic reverse;
        dcs_stop_t stop_kind;
    } dcs_cmd_t;

    typedef struct packed {
        logic tripped;
        logic controls_ready;
        logic drive_ready;
        logic motor_enabled;
        logic error_no_trip;
        logic trip_locked;
        logic warning;
        logic speed_at_ref;
        logic local_stop;
        logic ref_site_local;
        logic freq_in_limits;
        logic start_present;
        logic freq_nonzero;
        logic overtemp_auto;
        logic dc_voltage_bad;
        logic current_limit;
        logic thermal_timer;
        logic link_lost;
        logic comm_fault;
    } dcs_stat_t;

endpackage : dcs_pkg

// file: hdl/dcs_edge.sv
`timescale 1ns/100ps
// rising edge detector on a same-clock level
module dcs_edge (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_level,
    input wire logic i_arm,
    output logic o_rise
);
    logic prev_ff;
    logic nxt_prev;

    always_comb begin
        nxt_prev = i_arm ? i_level : prev_ff;
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= nxt_prev;
        end
    end

    assign o_rise = i_arm & i_level & ~prev_ff;
endmodule : dcs_edge

// file: hdl/dcs_word.sv
`timescale 1ns/100ps
`include "dcs_defs.svh"
// Function
// - command bits 1:0 pick one of four preset references
// - bit 2 low: DC brake and stop; high: normal ramping
// - bit 3 low: output stage off at once, motor coasts
// - bit 4 low: quick-stop ramp down to standstill
// - bit 5 low: freeze present output frequency
// - while frozen, only coast, DC brake or input stops the drive
// - bit 6 low: ramp stop; high: start allowed
// - trip reset only on rising edge of bit 7
// - bit 8 high: run at inching speed
// - word ignored unless bit 10 is high
// - bit 11 energises relay one when its function is option 36
// - bit 12 energises relay four when its function is option 37
// - bits 14:13 pick set-up one to four under multi set-up
// - bit 15 reverses only with bus, OR or AND source
// - status bits 0 to 2: controls ready, drive ready, enable
// - status bits 3,4,6,7: trip, error, triplock, warning; bit 5 zero
// - status bit 8 set only when speed equals reference
// - status bit 9 cleared on local stop or local reference site
// - status bit 10 in limits; bit 11 start or frequency above zero
// - status bits 12 to 15: overtemp, voltage, current, thermal timer
// - link loss or internal fault forces status word to zero
module dcs_word (
    // clock and reset
    input wire logic I_MCLK,
    input wire logic I_RST_N,
    // command word from bus interface
    input wire logic [15:0] I_COMMAND_WORD,
    input wire logic I_COMMAND_STROBE,
    // configuration
    input wire logic [7:0] I_RELAY1_FUNC,
    input wire logic [7:0] I_RELAY4_FUNC,
    input wire logic [3:0] I_ACTIVE_SETUP,
    input wire logic [1:0] I_REVERSE_SRC,
    input wire logic I_DIN_REVERSE,
    input wire logic I_DIN_STOP,
    // drive status
    input wire dcs_pkg::dcs_stat_t I_STAT,
    // decoded commands
    output dcs_pkg::dcs_cmd_t O_CMD,
    output logic O_CMD_TRIP_RESET,
    // status word to bus interface
    output logic [15:0] O_STATE_WORD
);
    logic [15:0] cmd_ff;
    logic [15:0] nxt_cmd;
    logic accept;
    dcs_pkg::dcs_cmd_t cmd_out_ff;
    dcs_pkg::dcs_cmd_t nxt_cmd_out;
    logic [15:0] state_ff;
    logic [15:0] nxt_state;
    logic reset_rise;
    logic reset_pulse_ff;
    logic nxt_reset_pulse;
    logic frozen;

    // --------------------------------------------------------------
    // command latch
    // --------------------------------------------------------------
    // valid gating
    assign accept = I_COMMAND_STROBE & I_COMMAND_WORD[`DCS_CW_VALID];

    always_comb begin
        nxt_cmd = accept ? I_COMMAND_WORD : cmd_ff;
    end

    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            cmd_ff <= `DCS_CMD_RESET;
        end else begin
            cmd_ff <= nxt_cmd;
        end
    end

    dcs_edge u_reset_edge (
        .i_mclk(I_MCLK),
        .i_rst_n(I_RST_N),
        .i_level(I_COMMAND_WORD[`DCS_CW_RESET]),
        .i_arm(accept),
        .o_rise(reset_rise)
    );

    // --------------------------------------------------------------
    // command decode
    // --------------------------------------------------------------
    always_comb begin
        nxt_cmd_out = '0;
        // hold comes from the latched word itself so it lands with the other bits
        frozen = ~cmd_ff[`DCS_CW_HOLD_N];
        nxt_reset_pulse = reset_rise;
        nxt_cmd_out.preset_sel = cmd_ff[`DCS_CW_PRESET_HI:`DCS_CW_PRESET_LO];
        nxt_cmd_out.dc_brake = ~cmd_ff[`DCS_CW_DC_BRAKE_N];
        nxt_cmd_out.coast = ~cmd_ff[`DCS_CW_COAST_N];
        nxt_cmd_out.hold_freq = frozen;
        nxt_cmd_out.quick_stop = ~cmd_ff[`DCS_CW_QSTOP_N] & ~frozen;
        nxt_cmd_out.ramp_stop = ~cmd_ff[`DCS_CW_START] & ~frozen;
        nxt_cmd_out.run_enable = cmd_ff[`DCS_CW_START] & cmd_ff[`DCS_CW_COAST_N]
            & cmd_ff[`DCS_CW_DC_BRAKE_N] & cmd_ff[`DCS_CW_QSTOP_N];
        nxt_cmd_out.trip_reset = reset_pulse_ff;
        nxt_cmd_out.jog = cmd_ff[`DCS_CW_JOG];
        nxt_cmd_out.ramp_set2 = cmd_ff[`DCS_CW_RAMP2];
        nxt_cmd_out.relay1 = cmd_ff[`DCS_CW_RELAY1] & (I_RELAY1_FUNC == `DCS_RELAY_OPT_BIT11);
        nxt_cmd_out.relay4 = cmd_ff[`DCS_CW_RELAY4] & (I_RELAY4_FUNC == `DCS_RELAY_OPT_BIT12);
        nxt_cmd_out.setup_sel = cmd_ff[`DCS_CW_SETUP_HI:`DCS_CW_SETUP_LO];
        nxt_cmd_out.setup_load = (I_ACTIVE_SETUP == `DCS_SETUP_OPT_MULTI);
        case (I_REVERSE_SRC)
            `DCS_REV_OPT_BUS: nxt_cmd_out.reverse = cmd_ff[`DCS_CW_REVERSE];
            `DCS_REV_OPT_OR: nxt_cmd_out.reverse = cmd_ff[`DCS_CW_REVERSE] | I_DIN_REVERSE;
            `DCS_REV_OPT_AND: nxt_cmd_out.reverse = cmd_ff[`DCS_CW_REVERSE] & I_DIN_REVERSE;
            default: nxt_cmd_out.reverse = I_DIN_REVERSE;
        endcase
        // stop priority: coast, dc brake, input stop (coast), then ramp kinds
        if (nxt_cmd_out.coast) begin
            nxt_cmd_out.stop_kind = dcs_pkg::DCS_STOP_COAST;
        end else if (nxt_cmd_out.dc_brake) begin
            nxt_cmd_out.stop_kind = dcs_pkg::DCS_STOP_DC_BRAKE;
        end else if (I_DIN_STOP) begin
            nxt_cmd_out.stop_kind = dcs_pkg::DCS_STOP_COAST;
        end else if (nxt_cmd_out.quick_stop | nxt_cmd_out.ramp_stop) begin
            nxt_cmd_out.stop_kind = dcs_pkg::DCS_STOP_RAMP;
        end else begin
            nxt_cmd_out.stop_kind = dcs_pkg::DCS_STOP_NONE;
        end
    end

    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            cmd_out_ff <= '0;
            reset_pulse_ff <= 1'b0;
        end else begin
            cmd_out_ff <= nxt_cmd_out;
            reset_pulse_ff <= nxt_reset_pulse;
        end
    end

    assign O_CMD = cmd_out_ff;
    assign O_CMD_TRIP_RESET = reset_pulse_ff;

    // --------------------------------------------------------------
    // status word
    // --------------------------------------------------------------
    always_comb begin
        nxt_state = `DCS_STATE_RESET;
        nxt_state[0] = I_STAT.controls_ready & ~I_STAT.tripped;
        nxt_state[1] = I_STAT.drive_ready;
        nxt_state[2] = I_STAT.motor_enabled;
        nxt_state[3] = I_STAT.tripped;
        nxt_state[4] = I_STAT.error_no_trip;
        nxt_state[6] = I_STAT.trip_locked;
        nxt_state[7] = I_STAT.warning;
        nxt_state[8] = I_STAT.speed_at_ref;
        nxt_state[9] = ~(I_STAT.local_stop | I_STAT.ref_site_local);
        nxt_state[10] = I_STAT.freq_in_limits;
        nxt_state[11] = I_STAT.start_present | I_STAT.freq_nonzero;
        nxt_state[12] = I_STAT.overtemp_auto;
        nxt_state[13] = I_STAT.dc_voltage_bad;
        nxt_state[14] = I_STAT.current_limit;
        nxt_state[15] = I_STAT.thermal_timer;
        if (I_STAT.link_lost | I_STAT.comm_fault) begin
            nxt_state = `DCS_STATE_RESET;
        end
    end

    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state_ff <= `DCS_STATE_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign O_STATE_WORD = state_ff;
endmodule : dcs_word

// file: bench/dcs_word_asserts.sv
`timescale 1ns/100ps
module dcs_word_asserts (
    // clock and reset
    input wire logic I_MCLK,
    input wire logic I_RST_N,
    // command side
    input wire logic [15:0] I_COMMAND_WORD,
    input wire logic I_COMMAND_STROBE,
    input wire logic [7:0] I_RELAY1_FUNC,
    input wire logic [7:0] I_RELAY4_FUNC,
    // status and results
    input wire dcs_pkg::dcs_stat_t I_STAT,
    input wire dcs_pkg::dcs_cmd_t O_CMD,
    input wire logic O_CMD_TRIP_RESET,
    input wire logic [15:0] O_STATE_WORD
);
    logic acc;
    logic p7_ff, nxt_p7;
    logic [1:0] age_ff, nxt_age;
    assign acc = I_COMMAND_STROBE & I_COMMAND_WORD[10];
    always_comb begin
        nxt_p7 = acc ? I_COMMAND_WORD[7] : p7_ff;
        nxt_age = (age_ff == 2'h3) ? age_ff : age_ff + 2'h1;
    end
    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            p7_ff <= 1'b0;
            age_ff <= 2'h0;
        end else begin
            p7_ff <= nxt_p7;
            age_ff <= nxt_age;
        end
    end
    default clocking dcs_cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RST_N);
    a_trip_rise: assert property (acc && I_COMMAND_WORD[7] && !p7_ff |=> O_CMD_TRIP_RESET)
        else $error("no trip reset pulse");
    a_trip_cause: assert property (O_CMD_TRIP_RESET |-> $past(acc && I_COMMAND_WORD[7] && !p7_ff))
        else $error("stray trip reset pulse");
    a_cmd_hold: assert property (age_ff == 2'h3 && $changed({O_CMD.preset_sel, O_CMD.jog, O_CMD.setup_sel})
        |-> $past(acc, 2)) else $error("command moved without valid word");
    a_relay_one: assert property (acc |-> ##2 O_CMD.relay1 ==
        ($past(I_COMMAND_WORD[11], 2) && $past(I_RELAY1_FUNC) == 8'h24)) else $error("relay one wrong");
    a_relay_four: assert property (acc |-> ##2 O_CMD.relay4 ==
        ($past(I_COMMAND_WORD[12], 2) && $past(I_RELAY4_FUNC) == 8'h25)) else $error("relay four wrong");
    a_link_zero: assert property (I_STAT.link_lost || I_STAT.comm_fault |=> O_STATE_WORD == 16'h0000)
        else $error("state word not cleared");
    a_spare_bit: assert property (O_STATE_WORD[5] == 1'b0)
        else $error("spare bit set");
    a_ready_bit: assert property (age_ff == 2'h3 |-> O_STATE_WORD[0] ==
        $past(I_STAT.controls_ready && !I_STAT.tripped && !I_STAT.link_lost && !I_STAT.comm_fault))
        else $error("ready bit wrong");
    a_frozen_stop: assert property (O_CMD.hold_freq |-> !O_CMD.quick_stop && !O_CMD.ramp_stop)
        else $error("ramp stop while frozen");
    c_accept: cover property (acc);
    c_trip: cover property (O_CMD_TRIP_RESET);
    c_link: cover property (I_STAT.link_lost ##1 O_STATE_WORD == 16'h0000);
endmodule : dcs_word_asserts
bind dcs_word dcs_word_asserts i_asserts (.I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_COMMAND_WORD(I_COMMAND_WORD),
    .I_COMMAND_STROBE(I_COMMAND_STROBE), .I_RELAY1_FUNC(I_RELAY1_FUNC), .I_RELAY4_FUNC(I_RELAY4_FUNC),
    .I_STAT(I_STAT), .O_CMD(O_CMD), .O_CMD_TRIP_RESET(O_CMD_TRIP_RESET), .O_STATE_WORD(O_STATE_WORD));

// file: bench/dcs_master.sv
`timescale 1ns/100ps
module dcs_master (
    // clock
    input wire logic i_clk,
    // command telegram
    output logic [15:0] o_word,
    output logic o_strobe
);
    initial begin
        o_word = 16'h0000;
        o_strobe = 1'b0;
    end
    task automatic send(input logic [15:0] w);
        @(negedge i_clk);
        o_word = w;
        o_strobe = 1'b1;
        @(negedge i_clk);
        o_word = ~w;
        o_strobe = 1'b0;
    endtask : send
endmodule : dcs_master

// file: bench/drive_control_status_word_bench.sv
`timescale 1ns/100ps
module drive_control_status_word_bench;
    logic I_MCLK = 1'b0;
    logic I_RST_N = 1'b0;
    logic [15:0] I_COMMAND_WORD;
    logic I_COMMAND_STROBE;
    logic [7:0] I_RELAY1_FUNC = 8'h00;
    logic [7:0] I_RELAY4_FUNC = 8'h00;
    logic [3:0] I_ACTIVE_SETUP = 4'h0;
    logic [1:0] I_REVERSE_SRC = 2'h0;
    logic I_DIN_REVERSE = 1'b0;
    logic I_DIN_STOP = 1'b0;
    dcs_pkg::dcs_stat_t I_STAT = '0;
    dcs_pkg::dcs_cmd_t O_CMD;
    logic O_CMD_TRIP_RESET;
    logic [15:0] O_STATE_WORD;
    int error_cnt = 0;
    int samples_checked = 0;
    int seed = 32'h3bda_3586;
    dcs_pkg::dcs_cmd_t cq[$];
    logic [15:0] sq[$];
    logic [1:0] ap = 2'h0;
    logic sp = 1'b0, p7 = 1'b0;
    dcs_pkg::dcs_stat_t s;
    always #2 I_MCLK = ~I_MCLK;
    dcs_master i_master (.i_clk(I_MCLK), .o_word(I_COMMAND_WORD), .o_strobe(I_COMMAND_STROBE));
    dcs_word i_dut (.I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_COMMAND_WORD(I_COMMAND_WORD),
        .I_COMMAND_STROBE(I_COMMAND_STROBE), .I_RELAY1_FUNC(I_RELAY1_FUNC), .I_RELAY4_FUNC(I_RELAY4_FUNC),
        .I_ACTIVE_SETUP(I_ACTIVE_SETUP), .I_REVERSE_SRC(I_REVERSE_SRC), .I_DIN_REVERSE(I_DIN_REVERSE),
        .I_DIN_STOP(I_DIN_STOP), .I_STAT(I_STAT), .O_CMD(O_CMD), .O_CMD_TRIP_RESET(O_CMD_TRIP_RESET),
        .O_STATE_WORD(O_STATE_WORD));
    function automatic logic [15:0] exp_st(input dcs_pkg::dcs_stat_t t);
        if (t.link_lost | t.comm_fault)
            return 16'h0000;
        return {t.thermal_timer, t.current_limit, t.dc_voltage_bad, t.overtemp_auto,
            t.start_present | t.freq_nonzero, t.freq_in_limits, ~(t.local_stop | t.ref_site_local),
            t.speed_at_ref, t.warning, t.trip_locked, 1'b0, t.error_no_trip, t.tripped, t.motor_enabled,
            t.drive_ready, t.controls_ready & ~t.tripped};
    endfunction : exp_st
    task automatic chk_cmd(input dcs_pkg::dcs_cmd_t e, input dcs_pkg::dcs_cmd_t g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %0t exp %h got %h", $time, e, g);
        end
    endtask : chk_cmd
    task automatic chk_st(input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %0t exp %h got %h", $time, e, g);
        end
    endtask : chk_st
    task automatic chk_pulse(input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %0t exp %h got %h", $time, e, g);
        end
    endtask : chk_pulse
    task automatic st(input dcs_pkg::dcs_stat_t t);
        @(negedge I_MCLK);
        I_STAT = t;
        sq.push_back(exp_st(t));
    endtask : st
    task automatic cmd(input logic [15:0] w);
        dcs_pkg::dcs_cmd_t e;
        logic [15:0] r;
        @(negedge I_MCLK);
        r = 16'($random(seed));
        I_RELAY1_FUNC = r[0] ? 8'h24 : 8'h25;
        I_RELAY4_FUNC = r[1] ? 8'h25 : 8'h24;
        I_ACTIVE_SETUP = r[2] ? 4'h9 : r[6:3];
        I_REVERSE_SRC = r[8:7];
        I_DIN_REVERSE = r[9];
        I_DIN_STOP = r[10];
        e = '0;
        e.preset_sel = w[1:0];
        e.dc_brake = ~w[2];
        e.coast = ~w[3];
        e.hold_freq = ~w[5];
        e.quick_stop = ~w[4] & w[5];
        e.ramp_stop = ~w[6] & w[5];
        e.run_enable = w[6] & w[3] & w[2] & w[4];
        e.trip_reset = w[7] & ~p7;
        e.jog = w[8];
        e.ramp_set2 = w[9];
        e.relay1 = w[11] & (I_RELAY1_FUNC == 8'h24);
        e.relay4 = w[12] & (I_RELAY4_FUNC == 8'h25);
        e.setup_sel = w[14:13];
        e.setup_load = I_ACTIVE_SETUP == 4'h9;
        e.reverse = (r[8:7] == 2'h0) ? r[9] : (r[8:7] == 2'h1) ? w[15] : (r[8:7] == 2'h2) ? (w[15] | r[9])
            : (w[15] & r[9]);
        if (!w[3])
            e.stop_kind = dcs_pkg::DCS_STOP_COAST;
        else if (!w[2])
            e.stop_kind = dcs_pkg::DCS_STOP_DC_BRAKE;
        else if (r[10])
            e.stop_kind = dcs_pkg::DCS_STOP_COAST;
        else if (e.quick_stop | e.ramp_stop)
            e.stop_kind = dcs_pkg::DCS_STOP_RAMP;
        else
            e.stop_kind = dcs_pkg::DCS_STOP_NONE;
        if (w[10]) begin
            cq.push_back(e);
            p7 = w[7];
        end
        i_master.send(w);
    endtask : cmd
    always @(posedge I_MCLK) begin
        ap <= {ap[0], I_COMMAND_STROBE & I_COMMAND_WORD[10]};
        sp <= sq.size() != 0;
    end
    always @(negedge I_MCLK) begin
        if (ap[0])
            chk_pulse(cq[0].trip_reset, O_CMD_TRIP_RESET);
        if (ap[1])
            chk_cmd(cq.pop_front(), O_CMD);
        if (sp)
            chk_st(sq.pop_front(), O_STATE_WORD);
    end
    task automatic end_of_test();
        if (error_cnt == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test
    initial begin
        #20000;
        error_cnt++;
        end_of_test();
    end
    initial begin
        repeat (5) @(posedge I_MCLK);
        @(negedge I_MCLK);
        I_RST_N = 1'b1;
        for (int i = 0; i < 48; i++) begin
            s = 19'($random(seed));
            if (i % 4 != 0)
                s[1:0] = 2'b00;
            st(s);
        end
        st('0);
        // steady level, ignored word, then a fresh rise
        cmd(16'h04a0);
        cmd(16'h04a0);
        cmd(16'h0020);
        cmd(16'h0400);
        cmd(16'h0080);
        cmd(16'h04a0);
        for (int i = 0; i < 80; i++)
            cmd(16'($random(seed)));
        repeat (6) @(negedge I_MCLK);
        // an expectation still queued means a result never appeared
        if (cq.size() != 0 || sq.size() != 0)
            error_cnt++;
        end_of_test();
    end
endmodule : drive_control_status_word_bench
